/* File: logic/sram_host_pkg.sv */
package sram_host_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 9;
   localparam int CLK_PERIOD_NS = 50;
   // write strobe low to device float, longest figure
   localparam int WRITE_STROBE_TO_FLOAT_TIME_NS = 7;
   localparam int WRITE_DATA_SETUP_TIME_NS = 10;
   localparam int WRITE_PULSE_NS = 15;
   localparam int READ_ACCESS_NS = 20;
   localparam int OE_FLOAT_NS = 9;
   // least times round up, at least one cycle
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_up
   localparam int FLOAT_CYC = cyc_up(WRITE_STROBE_TO_FLOAT_TIME_NS);
   localparam int SETUP_CYC = cyc_up(WRITE_DATA_SETUP_TIME_NS);
   localparam int WPULSE_CYC = cyc_up(WRITE_PULSE_NS);
   localparam int READ_CYC = cyc_up(READ_ACCESS_NS);
   localparam int TURN_CYC = cyc_up(OE_FLOAT_NS);
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   typedef enum logic [2:0] {
      ST_IDLE, ST_WSTART, ST_WDATA, ST_WEND, ST_RACC, ST_RDONE, ST_TURN
   } state_t;
endpackage : sram_host_pkg

/* File: logic/data_latch.sv */
`timescale 1ns/1ps
`default_nettype none
// holds the word returned by a read; output straight from a register
module data_latch
   import sram_host_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              load,
   input  wire logic [DATA_W-1:0] din,
   output var  logic [DATA_W-1:0] dout
);
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dout <= '0;
      end else if (load) begin
         dout <= din;
      end
   end
endmodule : data_latch
`default_nettype wire

/* File: logic/sram_host.sv */
// What this block does
// - write opens only while both selects are active and write strobe low
// - write data held stable across the rising edge that ends the write
// - strobe-ended write lasts float plus setup plus pulse time, enable held high
// - host never drives data while device may still drive its pins
`timescale 1ns/1ps
`default_nettype none
module sram_host
   import sram_host_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              reqValid,
   input  wire logic              reqWrite,
   input  wire logic [ADDR_W-1:0] reqAddr,
   input  wire logic [DATA_W-1:0] reqData,
   output logic                   reqReady,
   output logic                   rspValid,
   output logic [DATA_W-1:0]      rspData,
   output logic [ADDR_W-1:0]      wordAddress,
   output logic                   selectLowActive_n,
   output logic                   selectHighActive,
   output logic                   writeStrobe_n,
   output logic                   outputEnable_n,
   input  wire logic [DATA_W-1:0] dataPinsIn,
   output logic [DATA_W-1:0]      dataPinsOut,
   output logic                   dataPinsOe_n
);
   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   state_t           state;
   logic [CNT_W-1:0] cnt;
   logic             capture;

   function automatic logic [CNT_W-1:0] to_cnt(input int n);
      return CNT_W'(n - 1);
   endfunction : to_cnt

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= ST_IDLE;
         cnt   <= CNT_ZERO;
      end else if (cnt != CNT_ZERO) begin
         cnt <= cnt - 4'h1;
      end else begin
         case (state)
            ST_IDLE: begin
               if (reqValid && reqReady) begin
                  state <= reqWrite ? ST_WSTART : ST_RACC;
                  cnt   <= reqWrite ? to_cnt(FLOAT_CYC) : to_cnt(READ_CYC);
               end
            end
            // strobe low, pins left to float before host drives
            ST_WSTART: begin
               state <= ST_WDATA;
               cnt   <= to_cnt(SETUP_CYC + WPULSE_CYC);
            end
            ST_WDATA: begin
               state <= ST_WEND;
               cnt   <= CNT_ZERO;
            end
            // one cycle of data hold after the closing edge
            ST_WEND: begin
               state <= ST_IDLE;
            end
            ST_RACC: begin
               state <= ST_RDONE;
            end
            ST_RDONE: begin
               state <= ST_TURN;
               cnt   <= to_cnt(TURN_CYC);
            end
            ST_TURN: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // request side
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reqReady <= 1'b0;
      end else begin
         reqReady <= (state == ST_IDLE) && !(reqValid && reqReady);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wordAddress <= '0;
         dataPinsOut <= '0;
      end else if (state == ST_IDLE && reqValid && reqReady) begin
         wordAddress <= reqAddr;
         dataPinsOut <= reqData;
      end
   end

   // ------------------------------------------------------------
   // memory strobes
   // ------------------------------------------------------------
   // selects are two registers driven from one term, so they never split
   logic selNext;
   logic weNext;
   logic oeNext;
   // selects also stand through the hold cycle, so the strobe alone ends the write
   assign selNext = (state == ST_WSTART) || (state == ST_WDATA) || (state == ST_WEND)
                 || (state == ST_RACC) || (state == ST_RDONE);
   // write strobe closes the write, selects drop one cycle later
   assign weNext = (state == ST_WSTART) || (state == ST_WDATA);
   assign oeNext = (state == ST_RACC) || (state == ST_RDONE);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         selectLowActive_n <= 1'b1;
         selectHighActive  <= 1'b0;
      end else begin
         selectLowActive_n <= !selNext;
         selectHighActive  <= selNext;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         writeStrobe_n  <= 1'b1;
         outputEnable_n <= 1'b1;
      end else begin
         writeStrobe_n  <= !weNext;
         // enable held high through writes so the device never drives
         outputEnable_n <= !oeNext;
      end
   end

   // data driven only after float time, held through closing edge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dataPinsOe_n <= 1'b1;
      end else begin
         dataPinsOe_n <= !((state == ST_WDATA) || (state == ST_WEND));
      end
   end

   // ------------------------------------------------------------
   // read return
   // ------------------------------------------------------------
   assign capture = (state == ST_RDONE) && (cnt == CNT_ZERO);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rspValid <= 1'b0;
      end else begin
         rspValid <= capture;
      end
   end

   data_latch u_latch (
      .clk    (clk),
      .resetn (resetn),
      .load   (capture),
      .din    (dataPinsIn),
      .dout   (rspData)
   );
endmodule : sram_host
`default_nettype wire

/* File: verification/sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_model import sram_host_pkg::*; (
   input  wire logic [ADDR_W-1:0] wordAddress,
   input  wire logic              selectLowActive_n,
   input  wire logic              selectHighActive,
   input  wire logic              writeStrobe_n,
   input  wire logic              outputEnable_n,
   input  wire logic [DATA_W-1:0] hostData,
   input  wire logic              hostOe_n,
   output logic      [DATA_W-1:0] dataPins
);
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic [DATA_W-1:0] last = 9'h000;
   logic              sel;
   assign sel = !selectLowActive_n && selectHighActive;
   always @(sel, writeStrobe_n, outputEnable_n, wordAddress, hostData, hostOe_n) begin
      if (sel && !writeStrobe_n) mem[wordAddress] = hostData;
      if (!hostOe_n) dataPins = hostData;
      else if (sel && writeStrobe_n && !outputEnable_n) dataPins = mem[wordAddress];
      // floating pins toggle so a stale value never passes
      else dataPins = ~last;
      last = dataPins;
   end
endmodule : sram_model
`default_nettype wire

/* File: verification/sram_host_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_host_properties import sram_host_pkg::*; (
   input wire logic              clk,
   input wire logic              resetn,
   input wire logic              reqValid,
   input wire logic              reqWrite,
   input wire logic              reqReady,
   input wire logic              rspValid,
   input wire logic              selectLowActive_n,
   input wire logic              selectHighActive,
   input wire logic              writeStrobe_n,
   input wire logic              outputEnable_n,
   input wire logic [DATA_W-1:0] dataPinsOut,
   input wire logic              dataPinsOe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_select_mirror: assert property (selectHighActive == !selectLowActive_n)
      else $error("selects not mirrored");
   a_write_selected: assert property (!writeStrobe_n |-> !selectLowActive_n)
      else $error("write strobe without select");
   a_write_end_data: assert property ($rose(writeStrobe_n) |-> $stable(dataPinsOut) && !dataPinsOe_n)
      else $error("data not held at write end");
   a_write_length: assert property ($rose(writeStrobe_n) |-> !$past(writeStrobe_n, 2))
      else $error("write too short");
   a_host_drive_float: assert property (!dataPinsOe_n |-> outputEnable_n && $past(outputEnable_n))
      else $error("host drives while device may drive");
   a_drive_selected: assert property (!dataPinsOe_n |-> !selectLowActive_n)
      else $error("host drives while deselected");
   a_read_answer: assert property (reqValid && reqReady && !reqWrite |=> !reqReady ##2 rspValid)
      else $error("read answer late or early");
   a_reset_idle: assert property (disable iff (1'b0) !resetn |=> selectLowActive_n && writeStrobe_n && dataPinsOe_n)
      else $error("not idle in reset");
endmodule : sram_host_properties
bind sram_host sram_host_properties sram_host_properties_i (.clk, .resetn, .reqValid, .reqWrite,
   .reqReady, .rspValid, .selectLowActive_n, .selectHighActive, .writeStrobe_n, .outputEnable_n,
   .dataPinsOut, .dataPinsOe_n);
`default_nettype wire

/* File: verification/tb_sram_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sram_host import sram_host_pkg::*;;
   typedef struct {logic wr; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;} row_t;
   logic clk = 1'b0, resetn = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
   logic reqReady, rspValid, selectLowActive_n, selectHighActive, writeStrobe_n;
   logic outputEnable_n, dataPinsOe_n;
   logic [ADDR_W-1:0] reqAddr = 15'h0000, wordAddress;
   logic [DATA_W-1:0] reqData = 9'h000, rspData, dataPinsIn, dataPinsOut;
   int failures = 0, n_compared = 0, cyc = 0;
   // boundary and alternating-bit addresses and data, read back after all writes
   row_t rows [6] = '{'{1'b1, 15'h0000, 9'h1ff}, '{1'b1, 15'h7fff, 9'h000},
      '{1'b1, 15'h2aaa, 9'h155}, '{1'b0, 15'h0000, 9'h1ff}, '{1'b0, 15'h7fff, 9'h000},
      '{1'b0, 15'h2aaa, 9'h155}};
   sram_host sram_host_i (.clk, .resetn, .reqValid, .reqWrite, .reqAddr, .reqData, .reqReady,
      .rspValid, .rspData, .wordAddress, .selectLowActive_n, .selectHighActive, .writeStrobe_n,
      .outputEnable_n, .dataPinsIn, .dataPinsOut, .dataPinsOe_n);
   sram_model sram_model_i (.wordAddress, .selectLowActive_n, .selectHighActive, .writeStrobe_n,
      .outputEnable_n, .hostData(dataPinsOut), .hostOe_n(dataPinsOe_n), .dataPins(dataPinsIn));
   initial forever #25 clk = ~clk;
   task automatic end_sim();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   task automatic check(input string n, input logic [DATA_W-1:0] s, e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic xfer(input row_t r);
      @(negedge clk);
      reqValid = 1'b1;
      reqWrite = r.wr;
      reqAddr = r.a;
      reqData = r.d;
      while (reqReady !== 1'b1) @(negedge clk);
      @(posedge clk);
      @(negedge clk);
      reqValid = 1'b0;
      if (!r.wr) begin
         repeat (2) @(posedge clk);
         #1;
         check("rspValid", {8'h00, rspValid}, 9'h001);
         check("rspData", rspData, r.d);
      end
   endtask : xfer
   always @(posedge clk) begin
      cyc++;
      // hang guard well above the roughly 60 cycles needed
      if (cyc == 1000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      repeat (5) @(negedge clk);
      check("idle", {5'h00, selectLowActive_n, writeStrobe_n, dataPinsOe_n, reqReady}, 9'h00e);
      resetn = 1'b1;
      $display("test reset done");
      foreach (rows[i]) xfer(rows[i]);
      $display("test rows done");
      xfer('{1'b1, 15'h1234, 9'h0a5});
      xfer('{1'b0, 15'h1234, 9'h0a5});
      $display("test back_to_back done");
      reqWrite = 1'b1;
      reqValid = 1'b1;
      repeat (4) @(negedge clk);
      resetn = 1'b0;
      reqValid = 1'b0;
      repeat (2) @(negedge clk);
      check("abort", {5'h00, selectLowActive_n, writeStrobe_n, dataPinsOe_n, reqReady}, 9'h00e);
      resetn = 1'b1;
      xfer('{1'b0, 15'h2aaa, 9'h155});
      $display("test abort done");
      end_sim();
   end
endmodule : tb_sram_host
`default_nettype wire
